/* File: mds_pkg.sv */
// Purpose: Shared constants for the management serial slave and its host.
// Assumes: 100 MHz system clock on both ends.
// Notes:   Frame field sizes, opcodes, strap codes and host register map.
package mds_pkg;
   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int CLK_HZ = 100_000_000; // System clock rate
   localparam int CLK_PERIOD_NS = 10; // System clock period
   localparam int STRAP_DELAY_NS = 1000; // Strap settle time after reset
   localparam int STRAP_CYC =
      (STRAP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int MDC_MAX_HZ = 12_000_000; // Fastest management clock
   localparam int MDC_HALF_MIN =
      (CLK_HZ + 2 * MDC_MAX_HZ - 1) / (2 * MDC_MAX_HZ);
   localparam int MDC_HALF_DEF = 8; // Default half period, 160 ns clock

   // ------------------------------------------------------------------
   // Frame layout
   // ------------------------------------------------------------------
   localparam int HDR_BITS = 13; // Second start bit, opcode, addresses
   localparam int TA_BITS = 2; // Turnaround
   localparam int DATA_BITS = 16; // Data field
   localparam int PRE_BITS = 32; // Optional preamble
   localparam logic [3:0] ADDR_UPPER = 4'h0; // Fixed upper address bits
   localparam logic [1:0] ST_C22 = 2'h1; // Start pattern, short form
   localparam logic [1:0] ST_C45 = 2'h0; // Start pattern, extended form
   localparam logic [1:0] TA_WR = 2'h2; // Host turnaround on writes
   localparam logic [1:0] OP_C22_RD = 2'h2;
   localparam logic [1:0] OP_C22_WR = 2'h1;
   localparam logic [1:0] OP_C45_ADR = 2'h0;
   localparam logic [1:0] OP_C45_WR = 2'h1;
   localparam logic [1:0] OP_C45_RINC = 2'h2;
   localparam logic [4:0] IO_REG_ADDR = 5'h18; // Holds the I/O level
   localparam int IO_LEVEL_BIT = 13;

   // ------------------------------------------------------------------
   // Strap tie-off codes (what the strap pin is tied to)
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {
      MDS_TIE_GND = 3'h0,
      MDS_TIE_IND0 = 3'h1,
      MDS_TIE_IND1 = 3'h2,
      MDS_TIE_IND2 = 3'h3,
      MDS_TIE_SUPPLY = 3'h4
   } mds_tie_t;

   // ------------------------------------------------------------------
   // Host register map and command fields
   // ------------------------------------------------------------------
   localparam logic [7:0] HR_CMD = 8'h00;
   localparam logic [7:0] HR_WDATA = 8'h04;
   localparam logic [7:0] HR_RDATA = 8'h08;
   localparam logic [7:0] HR_STATUS = 8'h0c;
   localparam logic [7:0] HR_DIV = 8'h10;
   localparam int CMD_RA_LSB = 0;
   localparam int CMD_PA_LSB = 5;
   localparam int CMD_OP_LSB = 10;
   localparam int CMD_C45_BIT = 12;
   localparam int CMD_PRE_BIT = 13;
   localparam int RD_OE_MIN_IDX = 18; // Host drives bits at and above
endpackage : mds_pkg

/* File: mds_if.sv */
// Purpose: Management clock and shared data line between host and device.
// Assumes: External pull-up keeps the data line high when released.
// Notes:   The resolved line level is worked out here from the enables.
`timescale 1ns/1ns
interface mds_if;
   logic mdc; // Management clock, from host
   logic host_mdio_o; // Host data out
   logic host_mdio_oe; // Host drives the line
   logic dev_mdio_o; // Device data out
   logic dev_mdio_oe; // Device drives the line
   logic mdio; // Resolved line level

   // Pull-up gives a one when nobody drives
   assign mdio = host_mdio_oe ? host_mdio_o :
                 (dev_mdio_oe ? dev_mdio_o : 1'b1);

   modport host (output mdc, output host_mdio_o, output host_mdio_oe,
                 input mdio);
   modport dev (input mdc, output dev_mdio_o, output dev_mdio_oe,
                input mdio);
endinterface : mds_if

/* File: mds_dev.sv */
// Purpose: Device end of the management serial link with strap capture.
// Assumes: Clock and data arrive asynchronously and are synchronised.
// Notes:   Register contents live outside; one I/O level bit is held here.
`timescale 1ns/1ns
module mds_dev
   import mds_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   mds_if.dev mif,
   input wire logic [2:0] strap_tie,
   output logic [4:0] station_address,
   output logic io_supply_level,
   output logic strap_valid,
   output logic strap_bad,
   output logic reg_c45,
   output logic [4:0] reg_dev,
   output logic [15:0] reg_addr,
   output logic [15:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic [15:0] reg_rdata
);
   // ------------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      DS_IDLE = 2'h0,
      DS_HDR = 2'h1,
      DS_TA = 2'h3,
      DS_DATA = 2'h2
   } mds_dstate_t;

   mds_dstate_t state_q; // Frame state
   logic [3:0] cnt_q; // Bit counter within a field
   logic [15:0] shift_q; // Incoming bits
   logic [15:0] out_q; // Outgoing read data
   logic mdc_s1_q, mdc_s2_q, mdc_s3_q; // Clock synchroniser and history
   logic mdio_s1_q, mdio_s2_q; // Data synchroniser
   logic [2:0] tie_s1_q, tie_s2_q; // Strap synchroniser
   logic [$clog2(STRAP_CYC+1)-1:0] scnt_q; // Strap settle counter
   logic strap_done_q; // Strap has been taken
   logic [1:0] strap_q; // Captured strap bits
   logic bad_q; // Strap tied to an unused choice
   logic level_q; // I/O level field
   logic rise; // Management clock rising edge
   logic bitv; // Sampled data bit
   logic [12:0] hdr; // Completed header
   logic hdr_end; // Last header bit sampled
   logic data_end; // Last data bit sampled
   logic c45_q, rd_q, wr_q; // Frame kind for this station
   logic [1:0] op_q; // Opcode
   logic [4:0] ra_q; // Register or device field
   logic [15:0] c45_addr_q; // Extended register address
   logic rd_wait_q; // Read data due this cycle
   logic reg_rd_q, reg_wr_q; // Register port strobes
   logic [15:0] reg_addr_q, reg_wdata_q;
   logic [4:0] reg_dev_q;
   logic reg_c45_q; // Extended-form flag of the latest access
   logic o_q, oe_q; // Line drive
   logic [1:0] strap_dec; // Decoded strap tie
   logic [4:0] my_addr; // Own station address
   logic hdr_c45, hdr_match, hdr_rd;

   // ------------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------------
   // Two flops on every pin before any logic looks at it
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mdc_s1_q <= 1'b0;
         mdc_s2_q <= 1'b0;
         mdc_s3_q <= 1'b0;
         mdio_s1_q <= 1'b1;
         mdio_s2_q <= 1'b1;
         tie_s1_q <= 3'h0;
         tie_s2_q <= 3'h0;
      end else begin
         mdc_s1_q <= mif.mdc;
         mdc_s2_q <= mdc_s1_q;
         mdc_s3_q <= mdc_s2_q;
         mdio_s1_q <= mif.mdio;
         mdio_s2_q <= mdio_s1_q;
         tie_s1_q <= strap_tie;
         tie_s2_q <= tie_s1_q;
      end
   end

   assign rise = mdc_s2_q & ~mdc_s3_q;
   assign bitv = mdio_s2_q;

   // ------------------------------------------------------------------
   // Strap capture
   // ------------------------------------------------------------------
   // Map the tie-off to two bits; unused choice reads as ground
   always_comb begin
      case (tie_s2_q)
         MDS_TIE_GND: strap_dec = 2'h0;
         MDS_TIE_IND0: strap_dec = 2'h1;
         MDS_TIE_IND1: strap_dec = 2'h2;
         MDS_TIE_SUPPLY: strap_dec = 2'h3;
         default: strap_dec = 2'h0;
      endcase
   end

   // Wait for the pin to settle, take it once, never again
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         scnt_q <= '0;
         strap_done_q <= 1'b0;
         strap_q <= 2'h0;
         bad_q <= 1'b0;
      end else if (!strap_done_q) begin
         if (scnt_q == ($clog2(STRAP_CYC+1))'(STRAP_CYC)) begin
            strap_done_q <= 1'b1;
            strap_q <= strap_dec;
            bad_q <= (tie_s2_q == MDS_TIE_IND2) ||
                     (tie_s2_q > MDS_TIE_SUPPLY);
         end else begin
            scnt_q <= scnt_q + 1'b1;
         end
      end
   end

   assign my_addr = {ADDR_UPPER, strap_q[0]};

   // ------------------------------------------------------------------
   // Frame sequencing
   // ------------------------------------------------------------------
   assign hdr = {shift_q[11:0], bitv};
   assign hdr_end = rise && state_q == DS_HDR &&
                    cnt_q == 4'(HDR_BITS - 1);
   assign data_end = rise && state_q == DS_DATA &&
                     cnt_q == 4'(DATA_BITS - 1);
   assign hdr_c45 = (hdr[12] == ST_C45[0]);
   assign hdr_match = (hdr[9:5] == my_addr);
   assign hdr_rd = hdr_c45 ? hdr[11] : (hdr[11:10] == OP_C22_RD);

   // Walk the fields on each sampled clock rise
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_q <= DS_IDLE;
         cnt_q <= 4'h0;
         shift_q <= 16'h0;
      end else if (rise && strap_done_q) begin
         case (state_q)
            DS_IDLE: begin
               if (!bitv) begin
                  state_q <= DS_HDR;
                  cnt_q <= 4'h0;
               end
            end
            DS_HDR: begin
               shift_q <= {shift_q[14:0], bitv};
               if (cnt_q == 4'(HDR_BITS - 1)) begin
                  state_q <= DS_TA;
                  cnt_q <= 4'h0;
               end else begin
                  cnt_q <= cnt_q + 4'h1;
               end
            end
            DS_TA: begin
               if (cnt_q == 4'(TA_BITS - 1)) begin
                  state_q <= DS_DATA;
                  cnt_q <= 4'h0;
               end else begin
                  cnt_q <= cnt_q + 4'h1;
               end
            end
            DS_DATA: begin
               shift_q <= {shift_q[14:0], bitv};
               if (cnt_q == 4'(DATA_BITS - 1)) begin
                  state_q <= DS_IDLE;
               end else begin
                  cnt_q <= cnt_q + 4'h1;
               end
            end
            default: state_q <= DS_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Frame decode and register port
   // ------------------------------------------------------------------
   // Issue reads after the header and writes after the data
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         c45_q <= 1'b0;
         rd_q <= 1'b0;
         wr_q <= 1'b0;
         op_q <= 2'h0;
         ra_q <= 5'h0;
         c45_addr_q <= 16'h0;
         reg_rd_q <= 1'b0;
         reg_wr_q <= 1'b0;
         reg_addr_q <= 16'h0;
         reg_wdata_q <= 16'h0;
         reg_dev_q <= 5'h0;
         reg_c45_q <= 1'b0;
         rd_wait_q <= 1'b0;
         level_q <= 1'b0;
      end else begin
         reg_rd_q <= 1'b0;
         reg_wr_q <= 1'b0;
         rd_wait_q <= reg_rd_q;
         if (!strap_done_q &&
             scnt_q == ($clog2(STRAP_CYC+1))'(STRAP_CYC)) begin
            level_q <= strap_dec[1] ^ strap_dec[0];
         end
         if (hdr_end) begin
            c45_q <= hdr_c45;
            op_q <= hdr[11:10];
            ra_q <= hdr[4:0];
            rd_q <= hdr_match && hdr_rd;
            wr_q <= hdr_match && !hdr_rd;
            if (hdr_match && hdr_rd) begin
               reg_rd_q <= 1'b1;
               reg_c45_q <= hdr_c45;
               reg_dev_q <= hdr[4:0];
               reg_addr_q <= hdr_c45 ? c45_addr_q : {11'h0, hdr[4:0]};
               if (hdr_c45 && hdr[11:10] == OP_C45_RINC) begin
                  c45_addr_q <= c45_addr_q + 16'h1;
               end
            end
         end
         if (data_end && wr_q) begin
            if (c45_q && op_q == OP_C45_ADR) begin
               c45_addr_q <= {shift_q[14:0], bitv};
            end else begin
               reg_wr_q <= 1'b1;
               reg_c45_q <= c45_q;
               reg_dev_q <= ra_q;
               reg_addr_q <= c45_q ? c45_addr_q : {11'h0, ra_q};
               reg_wdata_q <= {shift_q[14:0], bitv};
               if (!c45_q && ra_q == IO_REG_ADDR) begin
                  level_q <= shift_q[IO_LEVEL_BIT - 1];
               end
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // Line drive
   // ------------------------------------------------------------------
   // Zero in second turnaround bit, then data MSB first, then release
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         o_q <= 1'b1;
         oe_q <= 1'b0;
         out_q <= 16'h0;
      end else begin
         if (rd_wait_q) begin
            out_q <= reg_rdata;
            if (!c45_q && ra_q == IO_REG_ADDR) begin
               out_q[IO_LEVEL_BIT] <= level_q;
            end
         end
         if (rise && strap_done_q) begin
            case (state_q)
               DS_TA: begin
                  if (cnt_q == 4'h0) begin
                     oe_q <= rd_q;
                     o_q <= 1'b0;
                  end else begin
                     o_q <= out_q[15];
                     out_q <= {out_q[14:0], 1'b0};
                  end
               end
               DS_DATA: begin
                  if (cnt_q == 4'(DATA_BITS - 1)) begin
                     oe_q <= 1'b0;
                     o_q <= 1'b1;
                  end else begin
                     o_q <= out_q[15];
                     out_q <= {out_q[14:0], 1'b0};
                  end
               end
               default: begin
                  oe_q <= 1'b0;
                  o_q <= 1'b1;
               end
            endcase
         end
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign mif.dev_mdio_o = o_q;
   assign mif.dev_mdio_oe = oe_q;
   assign station_address = my_addr;
   assign io_supply_level = level_q;
   assign strap_valid = strap_done_q;
   assign strap_bad = bad_q;
   assign reg_c45 = reg_c45_q;
   assign reg_dev = reg_dev_q;
   assign reg_addr = reg_addr_q;
   assign reg_wdata = reg_wdata_q;
   assign reg_wr = reg_wr_q;
   assign reg_rd = reg_rd_q;
endmodule : mds_dev

/* File: mds_host.sv */
// Purpose: Host end of the management serial link, driven by registers.
// Assumes: Software port with read data one cycle after the read strobe.
// Notes:   Host makes the management clock by dividing the system clock.
`timescale 1ns/1ns
module mds_host
   import mds_pkg::*;
#(
   parameter int HALF_DEF = MDC_HALF_DEF
)
(
   input wire logic clk,
   input wire logic rst_n,
   mds_if.host mif,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata
);
   // ------------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      HS_IDLE = 2'h0,
      HS_RUN = 2'h1,
      HS_GAP = 2'h3
   } mds_hstate_t;

   mds_hstate_t state_q; // Engine state
   logic [15:0] wdata_q; // Data to send
   logic [15:0] rdat_q; // Data received
   logic [7:0] half_q; // Half period in system clocks
   logic [7:0] dcnt_q; // Divider counter
   logic tick; // Half-period enable
   logic mdc_q, o_q, oe_q; // Pin drive
   logic [63:0] vec_q; // Preamble and frame bits
   logic [5:0] idx_q; // Bit being sent
   logic rd_q; // Current frame is a read
   logic mdio_s1_q, mdio_s2_q; // Data synchroniser
   logic [31:0] rdata_q; // Register read data
   logic start; // Command accepted
   logic cmd_c45, cmd_rd;
   logic [63:0] cmd_vec;

   // ------------------------------------------------------------------
   // Data input synchroniser
   // ------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mdio_s1_q <= 1'b1;
         mdio_s2_q <= 1'b1;
      end else begin
         mdio_s1_q <= mif.mdio;
         mdio_s2_q <= mdio_s1_q;
      end
   end

   // ------------------------------------------------------------------
   // Command build
   // ------------------------------------------------------------------
   assign start = wr && addr == HR_CMD && state_q == HS_IDLE;
   assign cmd_c45 = wdata[CMD_C45_BIT];
   assign cmd_rd = cmd_c45 ? wdata[CMD_OP_LSB + 1] :
                   (wdata[CMD_OP_LSB +: 2] == OP_C22_RD);
   assign cmd_vec = {{PRE_BITS{1'b1}}, (cmd_c45 ? ST_C45 : ST_C22),
                     wdata[CMD_OP_LSB +: 2], wdata[CMD_PA_LSB +: 5],
                     wdata[CMD_RA_LSB +: 5], TA_WR, wdata_q};

   // ------------------------------------------------------------------
   // Register port
   // ------------------------------------------------------------------
   // Writes set data and divider; reads answer one cycle later
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wdata_q <= 16'h0;
         half_q <= 8'(HALF_DEF);
         rdata_q <= 32'h0;
      end else begin
         if (wr && addr == HR_WDATA) begin
            wdata_q <= wdata[15:0];
         end
         if (wr && addr == HR_DIV) begin
            half_q <= (wdata[7:0] < 8'(MDC_HALF_MIN)) ?
                      8'(MDC_HALF_MIN) : wdata[7:0];
         end
         rdata_q <= 32'h0;
         if (rd) begin
            case (addr)
               HR_WDATA: rdata_q <= {16'h0, wdata_q};
               HR_RDATA: rdata_q <= {16'h0, rdat_q};
               HR_STATUS: rdata_q <= {31'h0, state_q != HS_IDLE};
               HR_DIV: rdata_q <= {24'h0, half_q};
               default: rdata_q <= 32'h0;
            endcase
         end
      end
   end

   // ------------------------------------------------------------------
   // Clock divider
   // ------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n || state_q == HS_IDLE) begin
         dcnt_q <= 8'h0;
      end else if (tick) begin
         dcnt_q <= 8'h0;
      end else begin
         dcnt_q <= dcnt_q + 8'h1;
      end
   end
   assign tick = (dcnt_q == half_q - 8'h1);

   // ------------------------------------------------------------------
   // Frame engine
   // ------------------------------------------------------------------
   // Launch on falling clock, sample read data on rising clock
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_q <= HS_IDLE;
         mdc_q <= 1'b0;
         o_q <= 1'b1;
         oe_q <= 1'b0;
         vec_q <= 64'h0;
         idx_q <= 6'h0;
         rd_q <= 1'b0;
         rdat_q <= 16'h0;
      end else begin
         case (state_q)
            HS_IDLE: begin
               if (start) begin
                  state_q <= HS_RUN;
                  vec_q <= cmd_vec;
                  rd_q <= cmd_rd;
                  idx_q <= wdata[CMD_PRE_BIT] ? 6'h3f : 6'h1f;
                  o_q <= wdata[CMD_PRE_BIT];
                  oe_q <= 1'b1;
               end
            end
            HS_RUN: begin
               if (tick) begin
                  mdc_q <= ~mdc_q;
                  if (!mdc_q) begin
                     if (rd_q && idx_q < 6'(DATA_BITS)) begin
                        rdat_q <= {rdat_q[14:0], mdio_s2_q};
                     end
                  end else if (idx_q == 6'h0) begin
                     state_q <= HS_GAP;
                     oe_q <= 1'b0;
                     o_q <= 1'b1;
                  end else begin
                     idx_q <= idx_q - 6'h1;
                     o_q <= vec_q[idx_q - 6'h1];
                     oe_q <= !rd_q ||
                             (idx_q - 6'h1) >= 6'(RD_OE_MIN_IDX);
                  end
               end
            end
            HS_GAP: begin
               if (tick) begin
                  mdc_q <= ~mdc_q;
                  if (mdc_q) begin
                     state_q <= HS_IDLE;
                  end
               end
            end
            default: state_q <= HS_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign mif.mdc = mdc_q;
   assign mif.host_mdio_o = o_q;
   assign mif.host_mdio_oe = oe_q;
   assign rdata = rdata_q;
endmodule : mds_host

/* File: mds_sva.sv */
// Purpose: Checks on the link between host end and device end.
// Assumes: 100 MHz clk, host half period 8 clocks.
// Notes:   Sees interface signals only.
`timescale 1ns/1ns
module mds_sva
(
   input logic clk,
   input logic rst_n,
   input logic mdc,
   input logic host_mdio_oe,
   input logic dev_mdio_o,
   input logic dev_mdio_oe
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   no_clash_a: assert property (!(host_mdio_oe && dev_mdio_oe))
      else $error("both ends drive");
   ta_released_a: assert property ($rose(dev_mdio_oe) |->
      !$past(host_mdio_oe, 8)) else $error("no released bit");
   ta_zero_a: assert property ($rose(dev_mdio_oe) |-> !dev_mdio_o)
      else $error("turnaround bit not zero");
   dev_launch_a: assert property ($rose(dev_mdio_oe) |-> mdc)
      else $error("drive start off clock");
   bit_step_a: assert property (dev_mdio_oe && $changed(dev_mdio_o)
      |-> mdc) else $error("bit change off clock");
   bit_hold_a: assert property ($rose(dev_mdio_oe) |=>
      dev_mdio_oe [*8]) else $error("bit too short");
   read_len_a: assert property ($rose(dev_mdio_oe) |->
      ##[266:278] $fell(dev_mdio_oe)) else $error("read length");
   mdc_half_a: assert property ($rose(mdc) |-> mdc [*5])
      else $error("clock too fast");
   frame_gap_a: assert property ($fell(host_mdio_oe) |->
      !host_mdio_oe [*8]) else $error("no idle gap");
endmodule : mds_sva

/* File: mds_tb.sv */
// Purpose: Host and device ends joined, driven through the host port.
// Assumes: Strap supply tie for link frames.
// Notes:   Device read data is a fixed pattern over the address.
`timescale 1ns/1ns
module testbench;
   import mds_pkg::*;
   logic clk = 0, rst_n = 0, hwr = 0, hrd = 0, lvl, bad;
   logic [7:0] haddr = 8'h00;
   logic [31:0] hwd = 32'h0, hrdata, v;
   logic [2:0] tie = 3'h0;
   logic [4:0] sa;
   logic [15:0] radr, rdv;
   logic [1:0] b;
   int mismatches = 0, checked = 0;
   logic sv, rc45, rwr, rrd;
   logic [4:0] rdev;
   logic [15:0] rwd;
   int nrd = 0, nwr = 0;
   mds_if mif();
   always #5 clk = ~clk;
   // Count register port strobes from the device end
   always @(posedge clk) begin
      if (rst_n) begin
         nrd <= nrd + int'(rrd);
         nwr <= nwr + int'(rwr);
      end
   end
   assign rdv = {11'h61a, radr[4:0]};
   mds_host i_mds_host (.clk(clk), .rst_n(rst_n), .mif(mif),
      .addr(haddr), .wdata(hwd), .wr(hwr), .rd(hrd), .rdata(hrdata));
   mds_dev i_mds_dev (.clk(clk), .rst_n(rst_n), .mif(mif),
      .strap_tie(tie), .station_address(sa), .io_supply_level(lvl),
      .strap_valid(sv), .strap_bad(bad), .reg_c45(rc45), .reg_dev(rdev),
      .reg_addr(radr), .reg_wdata(rwd), .reg_wr(rwr), .reg_rd(rrd),
      .reg_rdata(rdv));
   mds_sva i_mds_sva (.clk(clk), .rst_n(rst_n), .mdc(mif.mdc),
      .host_mdio_oe(mif.host_mdio_oe), .dev_mdio_o(mif.dev_mdio_o),
      .dev_mdio_oe(mif.dev_mdio_oe));
   task report_and_stop;
      if (mismatches == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : report_and_stop
   task chk(input string n, input logic [15:0] s, input logic [15:0] e);
      checked++;
      if (s !== e) begin
         mismatches++;
         $display("mismatch %s exp %h got %h", n, e, s);
      end
   endtask : chk
   task bw(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      haddr <= a;
      hwd <= d;
      hwr <= 1'b1;
      @(posedge clk);
      hwr <= 1'b0;
   endtask : bw
   task br(input logic [7:0] a);
      @(posedge clk);
      haddr <= a;
      hrd <= 1'b1;
      @(posedge clk);
      hrd <= 1'b0;
      #1 v = hrdata;
   endtask : br
   // One frame, then wait for busy to drop and fetch the result
   task xf(input logic [13:0] c, input logic [15:0] d);
      int i;
      bw(HR_WDATA, {16'h0, d});
      bw(HR_CMD, {18'h0, c});
      for (i = 0; i < 2000; i++) begin
         br(HR_STATUS);
         if (v[0] === 1'b0) break;
      end
      if (i == 2000) begin
         mismatches++;
         report_and_stop;
      end
      br(HR_RDATA);
   endtask : xf
   // Every strap tie; not taken early, later pin change ignored
   task t_strap;
      for (int t = 0; t < 5; t++) begin
         b = (t == 1) ? 2'h1 : (t == 2) ? 2'h2 : (t == 4) ? 2'h3 : 2'h0;
         @(posedge clk);
         tie <= 3'(t);
         rst_n <= 1'b0;
         repeat (4) @(posedge clk);
         rst_n <= 1'b1;
         repeat (50) @(posedge clk);
         chk("strap early", {15'h0, sv}, 16'h0);
         repeat (60) @(posedge clk);
         tie <= 3'h1;
         repeat (20) @(posedge clk);
         chk("strap", {8'h0, sv, bad, lvl, sa},
             {8'h0, 1'b1, t == 3, ^b, 4'h0, b[0]});
      end
   endtask : t_strap
   // Divider clamp of a too-fast setting, then back to default
   task t_div;
      bw(HR_DIV, 32'h3);
      br(HR_DIV);
      chk("div clamp", v[15:0], 16'(MDC_HALF_MIN));
      bw(HR_DIV, 32'(MDC_HALF_DEF));
      br(HR_DIV);
      chk("div", v[15:0], 16'(MDC_HALF_DEF));
   endtask : t_div
   // Short-form reads with and without preamble, foreign station
   task t_read;
      xf(14'h0825, 16'h0);
      chk("read", v[15:0], 16'hc345);
      xf(14'h2825, 16'h0);
      chk("read pre", v[15:0], 16'hc345);
      xf(14'h0845, 16'h0);
      chk("other station", v[15:0], 16'hffff);
   endtask : t_read
   // I/O level field: strapped value, software write, read back
   task t_level;
      xf(14'h0838, 16'h0);
      chk("level rd", v[15:0], 16'hc358);
      xf(14'h0438, 16'h2000);
      chk("level wr", {10'h0, lvl, sa}, 16'h0021);
      chk("wr port", {10'h0, rc45, rdev}, 16'h0018);
      chk("wr data", rwd, 16'h2000);
      xf(14'h0838, 16'h0);
      chk("level back", v[15:0], 16'he358);
   endtask : t_level
   // Extended form: address load, read, read with bump, bumped read
   task t_ext;
      xf(14'h1023, 16'h0007);
      xf(14'h1c23, 16'h0);
      chk("ext read", v[15:0], 16'hc347);
      chk("ext flag", {15'h0, rc45}, 16'h0001);
      xf(14'h1823, 16'h0);
      chk("ext rinc", v[15:0], 16'hc347);
      xf(14'h1c23, 16'h0);
      chk("ext bumped", v[15:0], 16'hc348);
      chk("reads", 16'(nrd), 16'h0007);
      chk("writes", 16'(nwr), 16'h0001);
   endtask : t_ext
   // Scenarios in order, then the verdict
   initial begin
      t_strap;
      t_div;
      t_read;
      t_level;
      t_ext;
      report_and_stop;
   end
endmodule : testbench
